// [adcrd_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module adcrd_checker #(
    parameter int PUP_CYC = 100,
    parameter int CONV_CYC = 230
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic convert_start_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic busy,
    input wire logic powered_up,
    input wire logic track_hold,
    input wire logic [7:0] data_oe
);
    localparam int CL = CONV_CYC - 1;
    localparam int CH = CONV_CYC + 1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ==========
    // pins
    start_down_a: assert property ($rose(arst_n) |-> !powered_up && !busy)
        else $error("up at reset");
    pulse_gap_a: assert property ($rose(powered_up) |-> !busy [*4])
        else $error("early busy");
    no_start_a: assert property (convert_start_n [*8] |=> !$rose(busy))
        else $error("stray busy");
    busy_len_a: assert property ($rose(busy) |-> ##[CL:CH] $fell(busy))
        else $error("busy length");
    up_before_busy_a: assert property ($rose(busy) |-> $past(powered_up, PUP_CYC))
        else $error("short power-up");
    hold_on_a: assert property ($rose(busy) |-> ##[0:1] track_hold)
        else $error("no hold");
    track_back_a: assert property ($fell(busy) |-> ##[0:1] !track_hold)
        else $error("no track");
    stay_up_a: assert property (convert_start_n [*4] ##1 $fell(busy) |-> powered_up [*3])
        else $error("went down");
    go_down_a: assert property (!convert_start_n [*4] ##1 $fell(busy) |-> ##[0:2] !powered_up)
        else $error("stayed up");
    bus_on_a: assert property ((!chip_select_n && !read_n) [*4] |=> data_oe == 8'hFF)
        else $error("bus off");
    bus_off_a: assert property ((chip_select_n || read_n) [*4] |=> data_oe == 8'h00)
        else $error("bus on");
endmodule : adcrd_checker
bind adcrd_top adcrd_checker #(.PUP_CYC(PUP_CYC), .CONV_CYC(CONV_CYC)) adcrd_checker_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .convert_start_n(convert_start_n), .chip_select_n(chip_select_n), .read_n(read_n),
    .busy(busy), .powered_up(powered_up), .track_hold(track_hold), .data_oe(data_oe));
`default_nettype wire

// [adcrd_host.sv]
`timescale 1ns/1ns
`default_nettype none
module adcrd_host (
    input wire logic sys_clk,
    input wire logic busy,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    output logic convert_start_n,
    output logic chip_select_n,
    output logic read_n
);
    // ==========
    // host
    initial {convert_start_n, chip_select_n, read_n} = 3'b011;
    task automatic conv(input int lead, input bit pd, output int n);
        n = lead;
        @(posedge sys_clk) convert_start_n <= 1'b1;
        repeat (lead) @(posedge sys_clk);
        convert_start_n <= 1'b0;
        while (!busy && n < 99) @(negedge sys_clk) n++;
        @(posedge sys_clk) convert_start_n <= !pd;
        for (int m = 0; busy && m < 99; m++) @(negedge sys_clk);
    endtask : conv
    // strobe outlasts the input sync lag; undriven bus reads inverted
    task automatic rd(output logic [7:0] b);
        @(posedge sys_clk) {chip_select_n, read_n} <= 2'b00;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk) b = (data_oe === 8'hFF) ? data_out : ~data_out;
        @(posedge sys_clk) {chip_select_n, read_n} <= 2'b11;
        repeat (12) @(posedge sys_clk);
    endtask : rd
endmodule : adcrd_host
`default_nettype wire

// [adcrd_pkg.sv]
package adcrd_pkg;
    // ==========================================================
    // timing
    localparam int ADCRD_CLK_HZ = 100_000_000;
    localparam int ADCRD_PUP_NS = 1000;
    localparam int ADCRD_CONV_NS = 2300;
    localparam int ADCRD_PUP_CYC = (ADCRD_PUP_NS * (ADCRD_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ADCRD_CONV_CYC = (ADCRD_CONV_NS * (ADCRD_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ADCRD_CNT_W = 16;
    // ==========================================================
    // result layout
    localparam int ADCRD_RES_W = 10;
    localparam int ADCRD_BUS_W = 8;
    localparam logic [5:0] ADCRD_LOW_PAD = 6'h00;
    localparam logic [9:0] ADCRD_RES_RST = 10'h000;
    localparam logic [7:0] ADCRD_BUS_RST = 8'h00;
    // ==========================================================
    // converter states
    typedef enum logic [1:0] {
        ADCRD_DOWN = 2'b00,
        ADCRD_PWRUP = 2'b01,
        ADCRD_IDLE = 2'b10,
        ADCRD_CONV = 2'b11
    } adcrd_state_t;
endpackage : adcrd_pkg

// [adcrd_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module adcrd_sync #(
    parameter int WIDTH = 3
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    adcrd_sync_if.sync port
);
    // ==========================================================
    // two stages; first stage feeds only the second
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            stable <= '0;
        end else begin
            meta <= port.raw;
            stable <= meta;
        end
    end
    assign port.synced = stable;
endmodule : adcrd_sync
`default_nettype wire

// [adcrd_sync_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface adcrd_sync_if;
    logic [2:0] raw;
    logic [2:0] synced;
    modport owner (output raw, input synced);
    modport sync (input raw, output synced);
endinterface : adcrd_sync_if
`default_nettype wire

// [adcrd_top.sv]
// Operation
// R1 - rising start edge fires 1 us pulse; code holds the pulse clear during conversion
// R2 - start low at pulse end: convert
// R3 - start high at pulse end: wait fall
// R4 - gated start is start OR pulse
// R5 - busy high during conversion
// R6 - conversion end: track, busy low, latch
// R7 - start high at busy fall: stay up
// R8 - start low at busy fall: power down
// R9 - power down wakes on rising edge
// R10 - host spaces starts past conversion plus read
// R11 - host uses fast mode above 100 kSPS
// R12 - drive bus only while cs, rd low; code drives data_oe three clocks behind the pins
// R13 - first read high byte, then low bits
// R14 - further reads keep alternating bytes
// R15 - busy rise resets byte pointer high
// R16 - host never reads while busy
// R17 - host ends read 100 ns early
// R18 - reads work while powered down
// R19 - come out of reset powered down
// R20 - pulse and conversion timed by counters
`timescale 1ns/1ns
`default_nettype none
module adcrd_top
    import adcrd_pkg::*;
#(
    parameter int PUP_CYC = ADCRD_PUP_CYC,
    parameter int CONV_CYC = ADCRD_CONV_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic convert_start_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic [ADCRD_RES_W-1:0] sample_code,
    output logic busy,
    output logic powered_up,
    output logic track_hold,
    output logic [ADCRD_BUS_W-1:0] data_out,
    output logic [ADCRD_BUS_W-1:0] data_oe
);
    // ==========================================================
    // local constants
    localparam int SYNC_W = 3;
    localparam int START_BIT = 2;
    localparam int CS_BIT = 1;
    localparam int RD_BIT = 0;
    // low bits of the result ride at the top of the second byte
    localparam int LOW_W = ADCRD_RES_W - ADCRD_BUS_W;

    // ==========================================================
    // pin synchronisers
    // strobes enter active high so the all-zero reset of the stages reads idle
    adcrd_sync_if sif ();
    assign sif.raw = {convert_start_n, !chip_select_n, !read_n};
    adcrd_sync #(.WIDTH(SYNC_W)) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .port(sif.sync)
    );
    logic start_s;
    logic cs_s;
    logic rd_s;
    assign start_s = sif.synced[START_BIT];
    assign cs_s = sif.synced[CS_BIT];
    assign rd_s = sif.synced[RD_BIT];

    // ==========================================================
    // state record
    typedef struct packed {
        adcrd_state_t st;
        logic start_d;
        logic rd_act_d;
        logic pulse;
        logic gated_d;
        logic [ADCRD_CNT_W-1:0] cnt;
        logic busy;
        logic pwr;
        logic track_hold;
        logic lsb_next;
        logic [ADCRD_RES_W-1:0] result;
        logic [ADCRD_BUS_W-1:0] dout;
        logic [ADCRD_BUS_W-1:0] doe;
    } adcrd_regs_t;

    localparam adcrd_regs_t REGS_RST = '{
        st: ADCRD_DOWN,
        start_d: 1'b0,
        rd_act_d: 1'b0,
        pulse: 1'b0,
        gated_d: 1'b0,
        cnt: '0,
        busy: 1'b0,
        pwr: 1'b0,
        track_hold: 1'b0,
        lsb_next: 1'b0,
        result: ADCRD_RES_RST,
        dout: ADCRD_BUS_RST,
        doe: ADCRD_BUS_RST
    };

    adcrd_regs_t r;
    adcrd_regs_t next_r;
    logic start_rise;
    logic gated;
    logic gated_fall;
    logic rd_act;
    logic conv_begin;

    // ==========================================================
    // next state
    always_comb begin
        next_r = r;
        start_rise = start_s && !r.start_d;
        gated = start_s || r.pulse; // R4
        gated_fall = r.gated_d && !gated;
        rd_act = cs_s && rd_s;
        conv_begin = 1'b0;
        next_r.start_d = start_s;
        next_r.gated_d = gated;
        next_r.rd_act_d = rd_act;

        // ==========================================================
        // power-up pulse
        // rising edge restarts the power-up pulse, except in conversion where the pulse is held clear
        if (start_rise) begin
            next_r.pulse = 1'b1; // R1
            next_r.cnt = ADCRD_CNT_W'(PUP_CYC - 1); // R20
        end else if (r.pulse) begin
            if (r.cnt == '0) begin
                next_r.pulse = 1'b0;
            end else begin
                next_r.cnt = r.cnt - 1'b1;
            end
        end

        // ==========================================================
        // converter sequencing
        case (r.st)
            ADCRD_DOWN: begin
                // only the core sleeps; the read port keeps serving the last result
                if (start_rise) begin
                    next_r.st = ADCRD_PWRUP; // R9 R19
                end
            end
            ADCRD_PWRUP: begin
                if (gated_fall) begin
                    conv_begin = 1'b1; // R2
                end else if (!r.pulse) begin
                    next_r.st = ADCRD_IDLE;
                end
            end
            ADCRD_IDLE: begin
                if (gated_fall) begin
                    conv_begin = 1'b1; // R3
                end
            end
            ADCRD_CONV: begin
                // pulse cannot run here: start edges in conversion are ignored for timing
                next_r.pulse = 1'b0;
                if (r.cnt == '0) begin
                    next_r.busy = 1'b0; // R6
                    next_r.track_hold = 1'b0; // R6
                    next_r.result = sample_code; // R6
                    if (start_s) begin
                        next_r.st = ADCRD_IDLE; // R7
                    end else begin
                        next_r.st = ADCRD_DOWN; // R8
                    end
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            default: begin
                next_r.st = ADCRD_DOWN;
            end
        endcase
        // single entry into conversion from either powered state
        if (conv_begin) begin
            next_r.st = ADCRD_CONV;
            next_r.busy = 1'b1; // R5
            next_r.track_hold = 1'b1;
            next_r.lsb_next = 1'b0; // R15
            next_r.cnt = ADCRD_CNT_W'(CONV_CYC - 1); // R20
        end
        next_r.pwr = (next_r.st != ADCRD_DOWN); // R19

        // ==========================================================
        // read port
        // busy rise wins over a read ending in the same cycle
        if (r.rd_act_d && !rd_act && r.st != ADCRD_CONV && !conv_begin) begin
            next_r.lsb_next = !r.lsb_next; // R14 R18
        end
        if (r.lsb_next) begin
            next_r.dout = {r.result[LOW_W-1:0], ADCRD_LOW_PAD}; // R13
        end else begin
            next_r.dout = r.result[ADCRD_RES_W-1:LOW_W]; // R13
        end
        if (rd_act) begin
            next_r.doe = '1; // R12
        end else begin
            next_r.doe = '0; // R12
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign busy = r.busy;
    assign track_hold = r.track_hold;
    assign powered_up = r.pwr;
    assign data_out = r.dout;
    assign data_oe = r.doe;
endmodule : adcrd_top
`default_nettype wire

// [test_adc_convert_start_and_byte_readout.sv]
`timescale 1ns/1ns
`default_nettype none
module test_adc_convert_start_and_byte_readout;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [9:0] sample_code = 10'h000;
    logic busy, powered_up, track_hold, cs_n, rd_n, cst_n;
    logic [7:0] data_out, data_oe, b;
    int fails = 0, cmp_count = 0, res, n, lead, lo;
    // model: bytes in read order, front first; each read rotates it
    int exp_q[$];
    bit was_down = 1'b1;
    localparam int PUP_T = 4;
    localparam int CONV_T = 8;
    always #5 sys_clk = ~sys_clk;
    adcrd_top #(.PUP_CYC(PUP_T), .CONV_CYC(CONV_T)) adcrd_top_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .convert_start_n(cst_n), .chip_select_n(cs_n), .read_n(rd_n), .sample_code(sample_code),
        .busy(busy), .powered_up(powered_up), .track_hold(track_hold), .data_out(data_out), .data_oe(data_oe));
    adcrd_host adcrd_host_i (.sys_clk(sys_clk), .busy(busy), .data_out(data_out), .data_oe(data_oe),
        .convert_start_n(cst_n), .chip_select_n(cs_n), .read_n(rd_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    // ==========
    // tests
    initial begin
        void'($urandom(45447));
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(negedge sys_clk) chk(8'(powered_up), 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) sample_code <= 10'($urandom);
            lead = i[0] ? 14 : 1;
            adcrd_host_i.conv(lead, i[1], n);
            // short lead out of power-down: the pulse, not the pin, sets the start
            lo = (was_down && lead < PUP_T) ? PUP_T + 2 : lead + 1;
            chk(8'(n >= lo && n <= lo + 6), 8'h01);
            was_down = i[1];
            res = sample_code;
            exp_q.delete();
            exp_q.push_back(res / 4);
            exp_q.push_back(res % 4 * 64);
            repeat (3) @(negedge sys_clk);
            chk(8'(powered_up), 8'(!i[1]));
            chk(8'(track_hold), 8'h00);
            for (int k = 0; k <= i % 3; k++) begin
                adcrd_host_i.rd(b);
                chk(b, 8'(exp_q[0]));
                exp_q.push_back(exp_q.pop_front());
            end
            $display("test %0d done", i);
        end
        summarize();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        summarize();
    end
endmodule : test_adc_convert_start_and_byte_readout
`default_nettype wire
